// >>> rtl/tcr_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_timer (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire tcr_pkg::tcr_sfr_s sfr_in,
    input  wire logic [7:0]        sfr_raddr_in,
    output logic [7:0]             sfr_rdata_out,
    input  wire logic              external_trigger_pin_in,
    input  wire logic              external_count_pin_in,
    output logic                   rx_baud_tick_out,
    output logic                   tx_baud_tick_out
);
    import tcr_pkg::*;

    logic [7:0]  ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    logic [1:0]  trg_sync;
    logic [1:0]  cnt_sync;
    logic        trg_prev;
    logic        cnt_prev;
    logic        baud_mode;
    logic        trg_fall;
    logic        cnt_fall;
    logic        inc;
    logic        ovf;
    logic        ext_event;
    logic        do_capture;
    logic        do_reload;
    logic        next_ovf_flag;
    logic        next_ext_flag;

    // ****************************************************************
    // Pin synchronisers and edge detect
    // ****************************************************************
    // Each pin passes two flip-flops before anything reads it, so a pin edge
    // acts on the counter three clocks after it reaches the pin.
    // The flops reset low while the pins idle high, so the release of reset
    // can only look like a rising edge, which nothing acts on.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trg_sync <= 2'h0;
            cnt_sync <= 2'h0;
            trg_prev <= 1'b0;
            cnt_prev <= 1'b0;
        end else begin
            trg_sync <= {trg_sync[0], external_trigger_pin_in};
            cnt_sync <= {cnt_sync[0], external_count_pin_in};
            trg_prev <= trg_sync[1];
            cnt_prev <= cnt_sync[1];
        end
    end

    assign trg_fall  = trg_prev & ~trg_sync[1];
    assign cnt_fall  = cnt_prev & ~cnt_sync[1];
    assign baud_mode = ctrl[TCR_BIT_RXSEL] | ctrl[TCR_BIT_TXSEL];

    // ****************************************************************
    // Event decode
    // ****************************************************************
    // Baud mode masks the trigger pin entirely: no capture, no reload and no
    // external flag, whatever the enable bit says.
    assign inc = ctrl[TCR_BIT_RUN] & (ctrl[TCR_BIT_CNT] ? cnt_fall : 1'b1);
    assign ovf = inc & (count == TCR_COUNT_MAX);
    assign ext_event  = trg_fall & ctrl[TCR_BIT_EXEN] & ~baud_mode;
    assign do_capture = ext_event & ctrl[TCR_BIT_CAP];
    assign do_reload  = ovf & (baud_mode | ~ctrl[TCR_BIT_CAP])
                      | ext_event & ~ctrl[TCR_BIT_CAP];

    assign rx_baud_tick_out = ovf & ctrl[TCR_BIT_RXSEL];
    assign tx_baud_tick_out = ovf & ctrl[TCR_BIT_TXSEL];

    // ****************************************************************
    // Control register
    // ****************************************************************
    // A flag set by hardware wins over a software clear in the same cycle, so
    // no event is lost. Writing 1 to a flag bit sets it, which lets software
    // exercise its flag handling without a real event.
    always_comb begin
        next_ovf_flag = ctrl[TCR_BIT_OVF];
        next_ext_flag = ctrl[TCR_BIT_EXT];
        if (sfr_in.wr && sfr_in.addr == TCR_ADDR_CONTROL) begin
            next_ovf_flag = sfr_in.wdata[TCR_BIT_OVF];
            next_ext_flag = sfr_in.wdata[TCR_BIT_EXT];
        end
        if (ovf && !baud_mode) begin
            next_ovf_flag = 1'b1;
        end
        if (ext_event) begin
            next_ext_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= TCR_RESET_BYTE;
        end else begin
            ctrl[TCR_BIT_OVF] <= next_ovf_flag;
            ctrl[TCR_BIT_EXT] <= next_ext_flag;
            if (sfr_in.wr && sfr_in.addr == TCR_ADDR_CONTROL) begin
                ctrl[5:0] <= sfr_in.wdata[5:0];
            end
        end
    end

    // ****************************************************************
    // Counter; a software write wins over counting in the same cycle
    // ****************************************************************
    // Each byte is written on its own; software that rewrites a running
    // counter should stop it first, or a carry may fall between the writes.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= TCR_RESET_WORD;
        end else if (sfr_in.wr && sfr_in.addr == TCR_ADDR_COUNT_LOW) begin
            count[7:0] <= sfr_in.wdata;
        end else if (sfr_in.wr && sfr_in.addr == TCR_ADDR_COUNT_HIGH) begin
            count[15:8] <= sfr_in.wdata;
        end else if (do_reload) begin
            count <= reload;
        end else if (inc) begin
            count <= count + 16'h0001;
        end
    end

    // ****************************************************************
    // Capture/reload pair
    // ****************************************************************
    // A capture wins over a software write to the pair, so a captured value
    // is never torn between old and new bytes.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reload <= TCR_RESET_WORD;
        end else if (do_capture) begin
            reload <= count;
        end else if (sfr_in.wr && sfr_in.addr == TCR_ADDR_RELOAD_LOW) begin
            reload[7:0] <= sfr_in.wdata;
        end else if (sfr_in.wr && sfr_in.addr == TCR_ADDR_RELOAD_HIGH) begin
            reload[15:8] <= sfr_in.wdata;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Read data is registered and shows the addressed register one clock
    // after the address is presented.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= TCR_RESET_BYTE;
        end else begin
            unique case (sfr_raddr_in)
                TCR_ADDR_CONTROL:     sfr_rdata_out <= ctrl;
                TCR_ADDR_RELOAD_LOW:  sfr_rdata_out <= reload[7:0];
                TCR_ADDR_RELOAD_HIGH: sfr_rdata_out <= reload[15:8];
                TCR_ADDR_COUNT_LOW:   sfr_rdata_out <= count[7:0];
                TCR_ADDR_COUNT_HIGH:  sfr_rdata_out <= count[15:8];
                default:              sfr_rdata_out <= TCR_RESET_BYTE;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_ovf_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ovf && !baud_mode |=> ctrl[TCR_BIT_OVF]) else $error("overflow flag not set");

    chk_ovf_flag_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ctrl[TCR_BIT_OVF] && !(sfr_in.wr && sfr_in.addr == TCR_ADDR_CONTROL)
            |=> ctrl[TCR_BIT_OVF])
        else $error("overflow flag cleared by hardware");

    chk_ovf_flag_baud: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(ctrl[TCR_BIT_OVF]) |-> !$past(baud_mode)
            || $past(sfr_in.wr && sfr_in.addr == TCR_ADDR_CONTROL))
        else $error("overflow flag set in baud mode");

    chk_ext_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ext_event |=> ctrl[TCR_BIT_EXT]) else $error("external flag not set");

    chk_ext_flag_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ctrl[TCR_BIT_EXT] && !(sfr_in.wr && sfr_in.addr == TCR_ADDR_CONTROL)
            |=> ctrl[TCR_BIT_EXT])
        else $error("external flag cleared by hardware");

    chk_rx_tick: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_baud_tick_out |-> ctrl[TCR_BIT_RXSEL] && count == TCR_COUNT_MAX)
        else $error("receive tick without overflow");

    chk_tx_tick: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tx_baud_tick_out |-> ctrl[TCR_BIT_TXSEL] && count == TCR_COUNT_MAX)
        else $error("transmit tick without overflow");

    chk_ext_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!ctrl[TCR_BIT_EXEN] || baud_mode) && !sfr_in.wr
            |=> $stable(ctrl[TCR_BIT_EXT]) && $stable(reload))
        else $error("trigger pin not ignored");

    chk_hold_stopped: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !ctrl[TCR_BIT_RUN] && !sfr_in.wr && !ext_event |=> $stable(count))
        else $error("count moved while stopped");

    chk_timer_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ctrl[TCR_BIT_RUN] && !ctrl[TCR_BIT_CNT] && !sfr_in.wr && !do_reload
            |=> count == $past(count) + 16'h0001)
        else $error("timer did not step");

    chk_count_pin_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ctrl[TCR_BIT_CNT] && !cnt_fall && !sfr_in.wr && !do_reload |=> $stable(count))
        else $error("counter moved without a pin edge");

    chk_capture_copy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        do_capture |=> reload == $past(count)) else $error("capture value wrong");

    chk_ovf_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ovf && !ctrl[TCR_BIT_CAP] && !sfr_in.wr |=> count == $past(reload))
        else $error("reload on overflow missing");

    chk_ext_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ext_event && !ctrl[TCR_BIT_CAP] && !sfr_in.wr |=> count == $past(reload))
        else $error("reload on trigger edge missing");

    chk_baud_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ovf && baud_mode && !sfr_in.wr |=> count == $past(reload))
        else $error("baud mode did not reload");

    chk_trig_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        trg_fall |-> $past(external_trigger_pin_in, 3) && !$past(external_trigger_pin_in, 2))
        else $error("trigger edge not from pin");

    chk_cnt_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cnt_fall |-> $past(external_count_pin_in, 3) && !$past(external_count_pin_in, 2))
        else $error("count edge not from pin");

endmodule : tcr_timer
`default_nettype wire

// >>> rtl/tcr_pkg.sv
package tcr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] TCR_ADDR_CONTROL     = 8'hC8;
    localparam logic [7:0] TCR_ADDR_RELOAD_LOW  = 8'hCA;
    localparam logic [7:0] TCR_ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] TCR_ADDR_COUNT_LOW   = 8'hCC;
    localparam logic [7:0] TCR_ADDR_COUNT_HIGH  = 8'hCD;
    localparam logic [7:0] TCR_RESET_BYTE       = 8'h00;
    localparam logic [15:0] TCR_RESET_WORD      = 16'h0000;
    localparam logic [15:0] TCR_COUNT_MAX       = 16'hFFFF;

    // ****************************************************************
    // Control bit positions
    // ****************************************************************
    localparam int TCR_BIT_OVF   = 7;
    localparam int TCR_BIT_EXT   = 6;
    localparam int TCR_BIT_RXSEL = 5;
    localparam int TCR_BIT_TXSEL = 4;
    localparam int TCR_BIT_EXEN  = 3;
    localparam int TCR_BIT_RUN   = 2;
    localparam int TCR_BIT_CNT   = 1;
    localparam int TCR_BIT_CAP   = 0;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcr_sfr_s;

endpackage : tcr_pkg

// >>> dv/tcr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_core_model (
    input  wire logic         clk_in,
    output var tcr_pkg::tcr_sfr_s sfr_out,
    output var logic [7:0]    raddr_out,
    input  wire logic [7:0]   rdata_in
);
    import tcr_pkg::*;
    initial begin
        sfr_out = '0;
        raddr_out = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        sfr_out <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_in);
        sfr_out.wr <= 1'b0;
    endtask : wr
    // Read data is registered, so it is taken one edge after the address.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        raddr_out <= a;
        @(posedge clk_in);
        @(negedge clk_in);
        d = rdata_in;
    endtask : rd
endmodule : tcr_core_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tcr_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic trig = 1'b1;
    logic cpin = 1'b1;
    tcr_sfr_s sfr;
    logic [7:0] raddr, rdata;
    logic rx_t, tx_t;
    logic [15:0] c, r;
    logic [39:0] e;
    logic [31:0] seed = 32'h0e48_d1a1;
    int fails = 0, samples_checked = 0, cycles = 0, rx_n = 0, tx_n = 0, n;
    logic [7:0] regs [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
    logic [7:0] baud [3] = '{8'h35, 8'h25, 8'h15};
    logic [7:0] trg [4] = '{8'h09, 8'h08, 8'h01, 8'h38};
    always #10 clk_in = ~clk_in;
    tcr_timer tcr_timer_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_in(sfr),
        .sfr_raddr_in(raddr), .sfr_rdata_out(rdata), .external_trigger_pin_in(trig),
        .external_count_pin_in(cpin), .rx_baud_tick_out(rx_t), .tx_baud_tick_out(tx_t));
    tcr_core_model tcr_core_model_inst (.clk_in(clk_in), .sfr_out(sfr), .raddr_out(raddr),
        .rdata_in(rdata));
    function automatic logic [15:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction : lfsr
    // Packs the expected control, reload pair and counter after one trigger edge.
    function automatic logic [39:0] trig_exp(input logic [7:0] m, input logic [15:0] c,
                                             input logic [15:0] r);
        if (!m[3] || m[5] || m[4]) return {m, r, c};
        if (m[0]) return {m | 8'h40, c, c};
        return {m | 8'h40, r, r};
    endfunction : trig_exp
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        tcr_core_model_inst.wr(a, d);
    endtask : w
    task automatic load(input logic [7:0] a, input logic [15:0] v);
        w(a, v[7:0]);
        w(a + 8'h01, v[15:8]);
    endtask : load
    task automatic chk(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] d;
        tcr_core_model_inst.rd(a, d);
        samples_checked++;
        if (d !== x) begin
            fails++;
            $display("BAD reg %h expected %h seen %h", a, x, d);
        end
    endtask : chk
    task automatic chk16(input logic [7:0] a, input logic [15:0] x);
        chk(a, x[7:0]);
        chk(a + 8'h01, x[15:8]);
    endtask : chk16
    task automatic chkb(input string nm, input logic x, input logic s);
        samples_checked++;
        if (s !== x) begin
            fails++;
            $display("BAD %s expected %b seen %b", nm, x, s);
        end
    endtask : chkb
    always @(posedge clk_in) begin
        if (rx_t === 1'b1) rx_n++;
        if (tx_t === 1'b1) tx_n++;
        cycles++;
        if (cycles == 4000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (regs[i]) chk(regs[i], 8'h00);
        r = lfsr() & 16'h7FFF;
        load(8'hCA, r);
        load(8'hCC, 16'hFFFF);
        w(8'hC8, 8'h04);
        chk(8'hC8, 8'h84);
        w(8'hC8, 8'h00);
        chk16(8'hCC, r + 16'h0003);
        foreach (baud[i]) begin
            load(8'hCA, 16'hFFFC);
            load(8'hCC, 16'hFFFF);
            rx_n = 0;
            tx_n = 0;
            w(8'hC8, baud[i]);
            repeat (20) @(posedge clk_in);
            chk(8'hC8, baud[i]);
            w(8'hC8, 8'h00);
            chk(8'hCD, 8'hFF);
            chkb("rx_tick", baud[i][5], rx_n != 0);
            chkb("tx_tick", baud[i][4], tx_n != 0);
        end
        foreach (trg[i]) begin
            c = lfsr();
            r = lfsr();
            load(8'hCA, r);
            load(8'hCC, c);
            w(8'hC8, trg[i]);
            trig <= 1'b0;
            repeat (6) @(posedge clk_in);
            trig <= 1'b1;
            e = trig_exp(trg[i], c, r);
            chk(8'hC8, e[39:32]);
            chk16(8'hCA, e[31:16]);
            chk16(8'hCC, e[15:0]);
        end
        c = lfsr() & 16'h7FFF;
        n = 1 + int'(lfsr() & 16'h0007);
        load(8'hCC, c);
        w(8'hC8, 8'h06);
        repeat (n) begin
            cpin <= 1'b0;
            repeat (4) @(posedge clk_in);
            cpin <= 1'b1;
            repeat (4) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
        w(8'hC8, 8'h02);
        chk16(8'hCC, c + n[15:0]);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (regs[i]) chk(regs[i], 8'h00);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
